// ==== design/flash_pin_core.sv ====
/*
 * Pin-level front end of a serial flash: select and standby, pause and
 * hardware reset on the shared fourth line, single/dual/quad shifting,
 * and status bits guarded by the write-protect line.
 * Assumes sck, chip select and data lines come from another clock domain
 * and that sck runs well below a quarter of clk.
 */
// Functional notes
// - Deselected: all output pins high impedance
// - Chip select low selects, leaves standby
// - First instruction only after select falling edge
// - Deselected: ignore input, stay in standby
// - Single mode drives data_line_one from falling
// - Dual/quad: lines bidirectional, rise in, fall out
// - Quad uses write-protect and pause lines as data
// - Lock set, protect low: status writes rejected
// - Lock clear: status writes always allowed
// - Quad enable disables write-protect pin function
// - Fourth line: data, else pause or reset
// - Pause keeps partial serial sequence intact
// - Paused and selected: output line high impedance
// - Reset pin low: reset mode, outputs off
// - Clock idle low or high, rising samples
`timescale 1ns/100ps
`include "flash_pin_map.svh"
module flash_pin_core
	import flash_pin_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         sck_pin,
	input  wire logic         chip_select_n,
	input  wire logic [3:0]   io_in,
	output logic      [3:0]   io_out,
	output logic      [3:0]   io_oe,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic      [31:0]  reg_rdata,
	output logic      [7:0]   rx_data,
	output logic              rx_valid,
	input  wire logic         rx_ready,
	input  wire logic [7:0]   tx_data,
	input  wire logic         tx_valid,
	output logic              tx_ready,
	output status_bits_t      status_q,
	output link_state_t       link_state
);

	logic [5:0]   pins_s;
	logic         sck_d_r;
	logic         cs_d_r;
	link_state_t  state_nxt;
	status_bits_t status_r;
	config_bits_t config_r;
	logic [7:0]   rx_sh_r;
	logic [3:0]   rx_cnt_r;
	logic [7:0]   tx_sh_r;
	logic [3:0]   tx_left_r;
	logic         drive_r;
	logic         pend_v_r;
	logic [7:0]   pend_d_r;
	logic         overrun_r;
	logic         reject_r;
	logic         buf_in_ready;
	logic [7:0]   rx_sh_nxt;
	logic [3:0]   out_bits;

	// Pins pass two flops before anything looks at them
	sync2 #(.W(6)) u_pin_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({sck_pin, chip_select_n, io_in}),
		.q       (pins_s)
	);

	wire       sck_s  = pins_s[5];
	wire       cs_n_s = pins_s[4];
	wire [3:0] io_s   = pins_s[3:0];

	// Edge finders; only rising and falling matter, so idle level is free
	wire rise    = sck_s & ~sck_d_r;
	wire fall    = ~sck_s & sck_d_r;
	wire cs_fell = cs_d_r & ~cs_n_s;

	// Shared pin roles
	wire qe        = status_r.quad_io_enable;
	wire wp_n_s    = io_s[2];
	wire ctl_n_s   = io_s[3];
	wire hw_rst    = ~qe & config_r.pin_function_select & ~ctl_n_s;
	wire pause_req = ~qe & ~config_r.pin_function_select & ~ctl_n_s;

	// Quad needs the enable; otherwise the two lines keep their roles
	wire is_quad = (config_r.lane_mode == lane_quad) & qe;
	wire is_dual = (config_r.lane_mode == lane_dual);
	wire [3:0] step = is_quad ? `STEP_QUAD :
	                  is_dual ? `STEP_DUAL : `STEP_SINGLE;
	wire [3:0] drive_mask = is_quad ? `DRIVE_QUAD :
	                        is_dual ? `DRIVE_DUAL : `DRIVE_SINGLE;

	// Lock is ignored while the protect pin is a data line
	wire st_wr_ok = ~status_r.status_lock_enable | wp_n_s | qe;

	wire active   = (link_state == st_sel);
	wire in_frame = active | (link_state == st_pause);
	wire tx_busy  = drive_r | (tx_left_r != 4'h0);
	// Wide modes share the lines, so no input while driving
	wire rx_en    = ~(tx_busy & (is_quad | is_dual));
	wire [3:0] rx_cnt_sum = rx_cnt_r + step;
	wire byte_done = active & rise & rx_en &
	                 (rx_cnt_sum == `BYTE_BITS);
	wire shift_out = active & fall & (tx_left_r != 4'h0);
	wire tx_load   = tx_valid & tx_ready;

	// Register decode
	wire sel_status = (reg_addr == `REG_STATUS);
	wire sel_config = (reg_addr == `REG_CONFIG);
	wire sel_link   = (reg_addr == `REG_LINK);
	wire wr_status  = reg_wr & sel_status;
	wire rej_now    = wr_status & ~st_wr_ok;
	wire rej_clr    = reg_wr & sel_link & reg_wdata[`LINK_REJ_BIT];
	wire ovr_now    = byte_done & pend_v_r & ~buf_in_ready;
	wire ovr_clr    = reg_wr & sel_link & reg_wdata[`LINK_OVR_BIT];

	wire [31:0] rd_status = 32'(status_r) << `STATUS_LSB;
	wire [31:0] rd_config = 32'(config_r);
	wire [31:0] rd_link   = 32'(link_state) |
	                        (32'(wp_n_s) << `LINK_WP_BIT) |
	                        (32'(overrun_r) << `LINK_OVR_BIT) |
	                        (32'(reject_r) << `LINK_REJ_BIT);
	wire [31:0] rd_value  = sel_status ? rd_status :
	                        sel_config ? rd_config :
	                        sel_link   ? rd_link   : 32'h0000_0000;

	// Input shift, lines taken MSB first
	always_comb begin
		if (is_quad)
			rx_sh_nxt = {rx_sh_r[3:0], io_s};
		else if (is_dual)
			rx_sh_nxt = {rx_sh_r[5:0], io_s[1:0]};
		else
			rx_sh_nxt = {rx_sh_r[6:0], io_s[0]};
	end

	// Output bits placed on the lines for the current mode
	always_comb begin
		if (is_quad)
			out_bits = tx_sh_r[7:4];
		else if (is_dual)
			out_bits = {2'b00, tx_sh_r[7:6]};
		else
			out_bits = {2'b00, tx_sh_r[7], 1'b0};
	end

	// Link state: a new frame starts only on a select falling edge
	always_comb begin
		state_nxt = link_state;
		unique case (link_state)
			st_idle: begin
				if (hw_rst)
					state_nxt = st_hwrst;
				else if (cs_fell)
					state_nxt = st_sel;
			end
			st_sel: begin
				if (hw_rst)
					state_nxt = st_hwrst;
				else if (cs_n_s)
					state_nxt = st_idle;
				else if (pause_req)
					state_nxt = st_pause;
			end
			st_pause: begin
				if (hw_rst)
					state_nxt = st_hwrst;
				else if (cs_n_s)
					state_nxt = st_idle;
				else if (~pause_req)
					state_nxt = st_sel;
			end
			st_hwrst: begin
				if (~hw_rst)
					state_nxt = st_idle;
			end
		endcase
	end

	// Reset at sys_rst leaves chip select armed only after a new fall
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link_state <= st_idle;
			sck_d_r    <= 1'b0;
			cs_d_r     <= 1'b0;
		end else begin
			link_state <= state_nxt;
			sck_d_r    <= sck_s;
			cs_d_r     <= cs_n_s;
		end
	end

	// Input shifter; outside a frame it is cleared, while paused frozen
	always_ff @(posedge clk) begin
		if (sys_rst | ~in_frame) begin
			rx_sh_r  <= 8'h00;
			rx_cnt_r <= 4'h0;
		end else if (active & rise & rx_en) begin
			rx_sh_r  <= rx_sh_nxt;
			rx_cnt_r <= byte_done ? 4'h0 : rx_cnt_sum;
		end
	end

	// Output shifter, advanced on falling sck edges only
	always_ff @(posedge clk) begin
		if (sys_rst | ~in_frame) begin
			tx_sh_r   <= 8'h00;
			tx_left_r <= 4'h0;
			drive_r   <= 1'b0;
			io_out    <= 4'h0;
		end else if (tx_load) begin
			tx_sh_r   <= tx_data;
			tx_left_r <= `BYTE_BITS;
		end else if (shift_out) begin
			io_out    <= out_bits;
			tx_sh_r   <= tx_sh_r << step;
			tx_left_r <= tx_left_r - step;
			drive_r   <= 1'b1;
		end else if (active & fall) begin
			drive_r   <= 1'b0;
		end
	end

	// Enables follow the drive flag, off outside selected state
	always_ff @(posedge clk) begin
		if (sys_rst)
			io_oe <= `DRIVE_NONE;
		else if (active & drive_r)
			io_oe <= drive_mask;
		else
			io_oe <= `DRIVE_NONE;
	end

	// Ready for a byte only when the shifter is empty
	always_ff @(posedge clk) begin
		if (sys_rst)
			tx_ready <= 1'b0;
		else
			tx_ready <= active & (tx_left_r == 4'h0) & ~tx_load;
	end

	// Held byte waits for the buffer; a second one overwrites it, so the held byte is lost and flagged
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_v_r <= 1'b0;
			pend_d_r <= 8'h00;
		end else if (byte_done) begin
			pend_v_r <= 1'b1;
			pend_d_r <= rx_sh_nxt;
		end else if (buf_in_ready) begin
			pend_v_r <= 1'b0;
		end
	end

	word_buf2 #(.W(8)) u_rx_buf (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_data   (pend_d_r),
		.in_valid  (pend_v_r),
		.in_ready  (buf_in_ready),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	// Sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			overrun_r <= 1'b0;
			reject_r  <= 1'b0;
		end else begin
			overrun_r <= ovr_now | (overrun_r & ~ovr_clr);
			reject_r  <= rej_now | (reject_r & ~rej_clr);
		end
	end

	// Registers; a status write refused when locked sets the reject flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_r <= '0;
			config_r <= '0;
		end else begin
			if (wr_status & st_wr_ok)
				status_r <= status_bits_t'(
					reg_wdata[`STATUS_LSB +: $bits(status_bits_t)]);
			if (reg_wr & sel_config)
				config_r <= config_bits_t'(
					reg_wdata[$bits(config_bits_t)-1:0]);
		end
	end

	// Read data stand one cycle, zero otherwise
	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rd_value : 32'h0000_0000;
	end

	// Copy of status bits for the core behind the pins
	always_ff @(posedge clk) begin
		if (sys_rst)
			status_q <= '0;
		else
			status_q <= status_r;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_desel_hiz_out: assert property (
		cs_n_s |-> ##2 (io_oe == `DRIVE_NONE))
		else $error("outputs enabled while deselected");

	a_select_entry: assert property (
		(link_state == st_idle) && cs_fell && !hw_rst
		|=> (link_state == st_sel))
		else $error("select edge did not select");

	a_no_fall_idle: assert property (
		(link_state == st_idle) && !cs_fell |=> (link_state != st_sel))
		else $error("selected without chip select falling edge");

	a_idle_no_byte: assert property (
		(link_state == st_idle) |-> !byte_done ##1 (rx_cnt_r == 4'h0))
		else $error("input taken while deselected");

	a_single_out_bit: assert property (
		shift_out && !is_quad && !is_dual && !tx_load
		|=> (io_out[1] == $past(tx_sh_r[7])) ##1 io_oe[1])
		else $error("single mode output bit wrong");

	a_rx_rise_only: assert property (
		!rise |=> $stable(rx_sh_r) || (rx_cnt_r == 4'h0))
		else $error("input shifted without rising edge");

	a_quad_all_lines: assert property (
		active && drive_r && is_quad |=> (io_oe == `DRIVE_QUAD))
		else $error("quad mode does not drive four lines");

	a_lock_rejects: assert property (
		wr_status && status_r.status_lock_enable && !wp_n_s && !qe
		|=> $stable(status_r) && reject_r)
		else $error("locked status write took effect");

	a_unlock_accepts: assert property (
		wr_status && !status_r.status_lock_enable
		|=> (status_r == $past(
			reg_wdata[`STATUS_LSB +: $bits(status_bits_t)])))
		else $error("unlocked status write lost");

	a_quad_overrides: assert property (
		wr_status && qe
		|=> (status_r == $past(
			reg_wdata[`STATUS_LSB +: $bits(status_bits_t)])))
		else $error("protect pin acted in quad mode");

	a_pause_hiz_hold: assert property (
		(link_state == st_pause) |=> (io_oe == `DRIVE_NONE))
		else $error("output enabled while paused");

	a_pause_frozen: assert property (
		(link_state == st_pause)
		|=> $stable(rx_cnt_r) && $stable(tx_left_r) && $stable(rx_sh_r))
		else $error("shift state moved while paused");

	a_reset_mode: assert property (
		(link_state != st_hwrst) && hw_rst
		|=> (link_state == st_hwrst) ##1 (io_oe == `DRIVE_NONE))
		else $error("reset line did not enter reset mode");

	c_byte_taken: cover property (byte_done ##[1:4] rx_valid);
	c_pause_resume: cover property (
		(link_state == st_pause) ##[1:50] (link_state == st_sel));
	c_hw_reset: cover property (link_state == st_hwrst);
	c_write_refused: cover property (rej_now);

endmodule

// ==== design/flash_pin_map.svh ====
/*
 * Register offsets, field positions and fixed counts of the serial flash
 * pin interface. Definitions only; included by the core.
 */
`ifndef FLASH_PIN_MAP_SVH
`define FLASH_PIN_MAP_SVH

// Register word offsets on the plain register port
`define REG_STATUS      8'h00
`define REG_CONFIG      8'h04
`define REG_LINK        8'h08

// Field positions inside the registers
`define STATUS_LSB      2
`define LINK_WP_BIT     2
`define LINK_OVR_BIT    3
`define LINK_REJ_BIT    4

// Bits per byte and bits moved per serial clock edge
`define BYTE_BITS       4'd8
`define STEP_SINGLE     4'd1
`define STEP_DUAL       4'd2
`define STEP_QUAD       4'd4

// Data lines driven in each lane mode
`define DRIVE_SINGLE    4'h2
`define DRIVE_DUAL      4'h3
`define DRIVE_QUAD      4'hf
`define DRIVE_NONE      4'h0

`endif

// ==== design/flash_pin_pkg.sv ====
/*
 * Types shared by the serial flash pin interface files.
 * Assumes flash_pin_map.svh sits on the include path.
 */
package flash_pin_pkg;

	// Link state, Gray coded along idle, selected, paused
	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_sel   = 2'b01,
		st_pause = 2'b11,
		st_hwrst = 2'b10
	} link_state_t;

	// Lane width of the serial transfer; 2'b10 is not a legal code
	typedef enum logic [1:0] {
		lane_single = 2'b00,
		lane_dual   = 2'b01,
		lane_quad   = 2'b11
	} lane_mode_t;

	// Protected status bits
	typedef struct packed {
		logic       status_lock_enable;
		logic       quad_io_enable;
		logic [3:0] block_protect_bits;
	} status_bits_t;

	// Pin and lane configuration
	typedef struct packed {
		logic       pin_function_select;
		lane_mode_t lane_mode;
	} config_bits_t;

endpackage

// ==== design/sync2.sv ====
/*
 * Two flip-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level or a clock far below clk.
 */
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// ==== design/word_buf2.sv ====
/*
 * Two-entry buffer with valid and ready on both sides.
 * Output data and valid come straight from flip-flops.
 */
`timescale 1ns/100ps
module word_buf2 #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic      [W-1:0] out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);

	logic         skid_v_r;
	logic [W-1:0] skid_d_r;

	// Ready drops only when both entries hold a word
	assign in_ready = ~skid_v_r;

	// Head entry refills from the skid entry first to keep order
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
			skid_v_r  <= 1'b0;
			skid_d_r  <= '0;
		end else if (~out_valid | out_ready) begin
			if (skid_v_r) begin
				out_valid <= 1'b1;
				out_data  <= skid_d_r;
				skid_v_r  <= 1'b0;
			end else begin
				out_valid <= in_valid;
				out_data  <= in_data;
			end
		end else if (in_valid & ~skid_v_r) begin
			skid_v_r <= 1'b1;
			skid_d_r <= in_data;
		end
	end

endmodule

// ==== test/flash_host_model.sv ====
/*
 * Host controller model: drives select, serial clock and the data lines.
 * Assumes the bench calls its tasks one at a time and never mid-edge.
 */
`timescale 1ns/100ps
module flash_host_model (
	input  wire logic       clk,
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe,
	output logic            sck,
	output logic            cs_n,
	output logic      [3:0] io
);
	localparam realtime H = 62.5;
	logic [3:0] hout = 4'hc;
	logic [3:0] hoe  = 4'hd;
	logic [3:0] seen = 4'h0;
	logic       cpol = 1'b0;
	logic       flt  = 1'b0;

	// Select held low through reset, so only a later fall counts
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
	end

	// Released lines toggle so a stale level never reads back
	always @(posedge clk)
		flt <= ~flt;
	always_comb
		for (int k = 0; k < 4; k++)
			io[k] = dev_oe[k] ? dev_out[k] : hoe[k] ? hout[k] : flt;

	task automatic cs(input logic v);
		cs_n = v;
	endtask

	// Idle level only changed while deselected
	task automatic mode(input logic c);
		cpol = c;
		sck = c;
	endtask

	// Protect, pause or reset line; never pulsed while an internal write runs
	task automatic pin(input int k, input logic v);
		hout[k] = v;
		repeat (6) @(posedge clk);
	endtask

	// Host bits MSB first, set up while low, taken on the rise
	task automatic put(input int n, input int bits, input logic [7:0] d);
		for (int i = 0; i < bits / n; i++) begin
			sck = 1'b0;
			for (int j = 0; j < n; j++)
				hout[j] = d[8 - n + j];
			d = d << n;
			#H sck = 1'b1;
			#H;
		end
		sck = cpol;
	endtask

	// Device shifts on the fall; host samples just before the rise
	task automatic get(input int n, output logic [7:0] v);
		logic [3:0] lane;
		v = 8'h00;
		seen = 4'h0;
		for (int i = 0; i < 8 / n; i++) begin
			sck = 1'b0;
			#H lane = (n == 1) ? {3'h0, io[1]} : io & 4'((1 << n) - 1);
			v = (v << n) | {4'h0, lane};
			seen = seen | dev_oe;
			sck = 1'b1;
			#H;
		end
		sck = cpol;
	endtask
endmodule

// ==== test/serial_flash_pin_interface_test.sv ====
/*
 * Bench for the flash pin core: register tasks, host traffic, checks.
 * Assumes design/ is on the include path and the host model is built.
 */
`timescale 1ns/100ps
module serial_flash_pin_interface_test
	import flash_pin_pkg::*;
;
	logic         clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         sck;
	logic         cs_n;
	logic [3:0]   io;
	logic [3:0]   dev_out;
	logic [3:0]   dev_oe;
	logic [7:0]   reg_addr;
	logic [31:0]  reg_wdata;
	logic         reg_wr;
	logic         reg_rd;
	logic [31:0]  reg_rdata;
	logic [7:0]   rx_data;
	logic         rx_valid;
	logic         rx_ready;
	logic [7:0]   tx_data;
	logic         tx_valid;
	logic         tx_ready;
	status_bits_t status_q;
	link_state_t  link_state;
	int           errors = 0;
	int           num_checks = 0;

	initial forever #2 clk = ~clk;

	flash_pin_core DUT (.clk(clk), .sys_rst(sys_rst), .sck_pin(sck),
		.chip_select_n(cs_n), .io_in(io), .io_out(dev_out), .io_oe(dev_oe),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .status_q(status_q),
		.link_state(link_state));
	flash_host_model HOST (.clk(clk), .dev_out(dev_out), .dev_oe(dev_oe),
		.sck(sck), .cs_n(cs_n), .io(io));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask

	task automatic close_out;
		if (errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Register port: one-cycle strobes, read data the cycle after
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask

	// Status write, then the protected bits after it lands
	task automatic wst(input logic [5:0] s, input logic [5:0] e);
		wr(8'h00, {24'h0, s, 2'b00});
		repeat (2) @(negedge clk);
		chk(status_q, e);
	endtask

	// Bounded waits: 0 receive valid, 1 transmit ready
	task automatic waitf(input int w);
		int i;
		for (i = 0; i < 400; i++) begin
			@(negedge clk);
			if ((w ? tx_ready : rx_valid) === 1'b1)
				break;
		end
		if (i == 400) begin
			chk(0, 1);
			close_out;
		end
	endtask

	task automatic waitst(input link_state_t s);
		int i;
		for (i = 0; i < 40 && link_state !== s; i++)
			@(negedge clk);
		chk(link_state, s);
	endtask

	task automatic rxc(input logic [7:0] e);
		waitf(0);
		chk(rx_data, e);
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
	endtask

	task automatic ldtx(input logic [7:0] d);
		@(posedge clk);
		tx_data <= d;
		tx_valid <= 1'b1;
		waitf(1);
		@(posedge clk);
		tx_valid <= 1'b0;
	endtask

	// Main sequence
	initial begin
		logic [7:0] b;
		reg_addr <= 8'h00;
		reg_wdata <= 32'h0000_0000;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		rx_ready <= 1'b0;
		tx_data <= 8'h00;
		tx_valid <= 1'b0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk(dev_oe, 4'h0);
		rdc(8'h00, 32'hffffffff, 32'h0);
		rdc(8'h08, 32'hffffffff, 32'h4);
		rdc(8'h0c, 32'hffffffff, 32'h0);
		HOST.put(1, 8, 8'h77);
		repeat (20) @(negedge clk);
		chk(rx_valid, 1'b0);
		HOST.cs(1'b1);
		repeat (6) @(negedge clk);
		HOST.cs(1'b0);
		waitst(st_sel);
		HOST.put(1, 8, 8'ha5);
		rxc(8'ha5);
		HOST.cs(1'b1);
		waitst(st_idle);
		chk(dev_oe, 4'h0);
		HOST.put(1, 8, 8'hff);
		repeat (20) @(negedge clk);
		chk(rx_valid, 1'b0);
		// Idle-high clock, single-line read with full duplex input
		HOST.mode(1'b1);
		HOST.cs(1'b0);
		waitst(st_sel);
		HOST.put(1, 8, 8'h3c);
		rxc(8'h3c);
		ldtx(8'h96);
		HOST.get(1, b);
		chk(b, 8'h96);
		chk(HOST.seen, 4'h2);
		rxc(8'h00);
		// Pause mid-byte with the output driving
		ldtx(8'h5a);
		HOST.put(1, 4, 8'hc0);
		chk(dev_oe, 4'h2);
		HOST.pin(3, 1'b0);
		waitst(st_pause);
		chk(dev_oe, 4'h0);
		HOST.put(1, 4, 8'hf0);
		HOST.pin(3, 1'b1);
		waitst(st_sel);
		HOST.put(1, 4, 8'h30);
		rxc(8'hc3);
		// Receiver stalls until the buffer overruns
		for (int k = 1; k < 5; k++)
			HOST.put(1, 8, 8'(k * 8'h11));
		rdc(8'h08, 32'h8, 32'h8);
		rxc(8'h11);
		rxc(8'h22);
		@(posedge clk);
		rx_ready <= 1'b1;
		repeat (4) @(posedge clk);
		rx_ready <= 1'b0;
		wr(8'h08, 32'h18);
		rdc(8'h08, 32'h18, 32'h0);
		HOST.cs(1'b1);
		waitst(st_idle);
		// Status guard by lock, protect line and quad enable
		wst(6'h25, 6'h25);
		HOST.pin(2, 1'b0);
		wst(6'h00, 6'h25);
		rdc(8'h08, 32'h1c, 32'h10);
		wr(8'h08, 32'h10);
		HOST.pin(2, 1'b1);
		wst(6'h3a, 6'h3a);
		HOST.pin(2, 1'b0);
		wst(6'h33, 6'h33);
		wst(6'h0f, 6'h0f);
		wst(6'h05, 6'h05);
		rdc(8'h00, 32'hffffffff, 32'h14);
		HOST.pin(2, 1'b1);
		// Dual then quad transfers both ways
		wst(6'h10, 6'h10);
		wr(8'h04, 32'h1);
		HOST.hoe = 4'hf;
		HOST.cs(1'b0);
		waitst(st_sel);
		HOST.put(2, 8, 8'h9c);
		rxc(8'h9c);
		ldtx(8'he1);
		HOST.hoe = 4'hc;
		HOST.get(2, b);
		chk(b, 8'he1);
		chk(HOST.seen, 4'h3);
		wr(8'h04, 32'h3);
		HOST.hoe = 4'hf;
		HOST.put(4, 8, 8'h5e);
		rxc(8'h5e);
		ldtx(8'h3b);
		HOST.hoe = 4'h0;
		HOST.get(4, b);
		chk(b, 8'h3b);
		chk(HOST.seen, 4'hf);
		HOST.hoe = 4'hf;
		HOST.pin(3, 1'b0);
		repeat (20) @(negedge clk);
		chk(link_state, st_sel);
		HOST.cs(1'b1);
		waitst(st_idle);
		// Fourth line as hardware reset
		wst(6'h00, 6'h00);
		wr(8'h04, 32'h4);
		rdc(8'h04, 32'hffffffff, 32'h4);
		HOST.hoe = 4'hd;
		HOST.pin(3, 1'b1);
		HOST.cs(1'b0);
		waitst(st_sel);
		HOST.pin(3, 1'b0);
		waitst(st_hwrst);
		chk(dev_oe, 4'h0);
		close_out;
	end
endmodule
